// [core/tlar_core.sv]
// Temperature limit registers, ambient result register and alert compare.
// ------------------------------------------------------------
// How it works
// RQ1: Upper, lower, critical limits at pointers 2-4.
// RQ2: Limits hold 11-bit signed quarter-degree values.
// RQ3: Bits 15-13 and 1-0 read zero, ignore writes.
// RQ4: Bit 12 is the limit sign bit.
// RQ5: Bits 11-2 store the limit magnitude bits.
// RQ6: Enabled alert asserts when temperature crosses limits; with alert_crit_only set, only the critical limit asserts it.
// RQ7: Read-only ambient register at pointer 5.
// RQ8: Ambient bits 12-0 double-buffered against conversions.
// RQ9: Each result loaded in parallel per conversion.
// RQ10: Bit 15 set when ambient at/above critical.
// RQ11: Bit 14 set when ambient above upper.
// RQ12: Bit 13 set when ambient below lower.
// RQ13: Window lock blocks upper and lower writes.
// RQ14: Quarter-degree resolution keeps two low bits zero.
// RQ15: Comparisons are signed with aligned quarter-degree fields.
// RQ16: Flags recomputed at each load with current limits.
// ------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
module tlar_core #(
   parameter int temp_width = 13
) (
   input  wire logic                     ref_clk,
   input  wire logic                     sys_rst,
   input  wire tlar_pkg::tlar_access_type host_access,
   output logic                          read_valid,
   output logic [15:0]                   read_data,
   input  wire logic                     conversion_done,
   input  wire logic [temp_width-1:0]    conversion_result,
   input  wire logic                     window_lock,
   input  wire logic                     alert_enable,
   input  wire logic                     alert_crit_only,
   output logic                          alert_active
);

   localparam int lim_w = tlar_pkg::limit_msb - tlar_pkg::limit_lsb + 1;

   if (temp_width != tlar_pkg::temp_msb + 1) begin
      $error("tlar_core: temp_width must match the ambient field");
   end

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // A limit sits at the quarter-degree step, so two zero bits bring it
   // onto the ambient grid before a signed compare.
   function automatic logic signed [12:0] align_limit(
      input logic [lim_w-1:0] lim
   );
      align_limit = signed'({lim, 2'b00}); // [RQ15]
   endfunction

   function automatic tlar_pkg::tlar_sel_type decode_limit(
      input logic [7:0] ptr
   );
      unique case (ptr)
         tlar_pkg::ptr_upper_limit:    decode_limit = tlar_pkg::tlar_sel_upper;
         tlar_pkg::ptr_lower_limit:    decode_limit = tlar_pkg::tlar_sel_lower;
         tlar_pkg::ptr_critical_limit: decode_limit = tlar_pkg::tlar_sel_crit;
         default:                      decode_limit = tlar_pkg::tlar_sel_none;
      endcase
   endfunction

   // ------------------------------------------------------------
   // Limit writes
   // ------------------------------------------------------------
   tlar_pkg::tlar_sel_type wr_sel;
   tlar_pkg::tlar_sel_type rd_sel;
   logic                   wr_allowed;
   logic [lim_w-1:0]       upper_q;
   logic [lim_w-1:0]       lower_q;
   logic [lim_w-1:0]       crit_q;
   logic [lim_w-1:0]       store_rd;

   assign wr_sel = decode_limit(host_access.pointer); // [RQ1]
   assign rd_sel = decode_limit(host_access.pointer);

   always_comb begin
      wr_allowed = host_access.write_en;
      if (wr_sel == tlar_pkg::tlar_sel_none) begin
         wr_allowed = 1'b0;
      end
      if (window_lock && (wr_sel == tlar_pkg::tlar_sel_upper ||
                          wr_sel == tlar_pkg::tlar_sel_lower)) begin
         wr_allowed = 1'b0; // [RQ13]
      end
   end

   // Only bits 12..2 are kept; the rest is dropped on write. [RQ3] [RQ5]
   tlar_limit_store #(
      .width(lim_w)
   ) u_store (
      .ref_clk     (ref_clk),
      .sys_rst     (sys_rst),
      .write_en    (wr_allowed),
      .write_index (2'(wr_sel)),
      .write_data  (host_access.write_data[tlar_pkg::limit_msb:
                                           tlar_pkg::limit_lsb]), // [RQ2]
      .read_index  (2'(rd_sel)),
      .read_data   (store_rd),
      .upper       (upper_q),
      .lower       (lower_q),
      .critical    (crit_q)
   );

   // ------------------------------------------------------------
   // Ambient result and flags
   // ------------------------------------------------------------
   logic [15:0]             ambient;
   logic signed [12:0]      next_temp;
   logic                    next_crit;
   logic                    next_upper;
   logic                    next_lower;

   always_comb begin
      next_temp = signed'(conversion_result);
      next_temp[tlar_pkg::quarter_lsb-1:0] = 2'b00; // [RQ14]
      next_crit  = next_temp >= align_limit(crit_q);  // [RQ10] [RQ15]
      next_upper = next_temp >  align_limit(upper_q); // [RQ11]
      next_lower = next_temp <  align_limit(lower_q); // [RQ12]
   end

   // The holding copy changes only on a completed conversion, so a host
   // read never sees half of an old and half of a new result.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         ambient <= tlar_pkg::ambient_reset;
      end else if (conversion_done) begin
         ambient <= {next_crit, next_upper, next_lower,
                     next_temp}; // [RQ8] [RQ9] [RQ16]
      end
   end

   // ------------------------------------------------------------
   // Alert output
   // ------------------------------------------------------------
   // The alert follows the flags of the last loaded result, so while enabled it
   // only moves once per conversion period; clearing alert_enable drops it at the next clock edge.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         alert_active <= 1'b0;
      end else if (!alert_enable) begin
         alert_active <= 1'b0;
      end else if (conversion_done) begin
         alert_active <= next_crit ||
                         (!alert_crit_only && (next_upper || next_lower)); // [RQ6]
      end
   end

   // ------------------------------------------------------------
   // Host reads
   // ------------------------------------------------------------
   logic       rd_pending;
   logic [7:0] rd_ptr;

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         rd_pending <= 1'b0;
         rd_ptr     <= 8'h00;
      end else begin
         rd_pending <= host_access.read_en;
         rd_ptr     <= host_access.pointer;
      end
   end

   // The limit store answers one cycle late, so the word is formed in the
   // second cycle; the ambient word is taken at that same moment.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         read_valid <= 1'b0;
         read_data  <= 16'h0000;
      end else begin
         read_valid <= rd_pending;
         if (rd_pending) begin
            if (rd_ptr == tlar_pkg::ptr_ambient_temp) begin
               read_data <= ambient; // [RQ7]
            end else if (decode_limit(rd_ptr) != tlar_pkg::tlar_sel_none) begin
               read_data <= {3'b000, store_rd, 2'b00}; // [RQ3] [RQ4]
            end else begin
               read_data <= 16'h0000;
            end
         end
      end
   end

endmodule
`default_nettype wire

// [shared/tlar_pkg.sv]
// Package with register map, field layout and shared types of the limit block.
package tlar_pkg;

   // ------------------------------------------------------------
   // Register pointers
   // ------------------------------------------------------------
   localparam logic [7:0] ptr_upper_limit    = 8'h02;
   localparam logic [7:0] ptr_lower_limit    = 8'h03;
   localparam logic [7:0] ptr_critical_limit = 8'h04;
   localparam logic [7:0] ptr_ambient_temp   = 8'h05;

   // ------------------------------------------------------------
   // Field layout
   // ------------------------------------------------------------
   localparam int limit_lsb       = 2;
   localparam int limit_msb       = 12;
   localparam int temp_msb        = 12;
   localparam int flag_crit_bit   = 15;
   localparam int flag_upper_bit  = 14;
   localparam int flag_lower_bit  = 13;
   localparam int quarter_lsb     = 2;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [15:0] limit_reset   = 16'h0000;
   localparam logic [15:0] ambient_reset = 16'h0000;

   // Host register access, one word per cycle.
   typedef struct packed {
      logic        write_en;
      logic        read_en;
      logic [7:0]  pointer;
      logic [15:0] write_data;
   } tlar_access_type;

   // Limit-register write targets, selected by the decoder.
   typedef enum logic [1:0] {
      tlar_sel_none,
      tlar_sel_upper,
      tlar_sel_lower,
      tlar_sel_crit
   } tlar_sel_type;

endpackage

// [core/tlar_limit_store.sv]
// Small memory holding the three limit words with a registered read port.
`timescale 1ns/10ps
`default_nettype none
module tlar_limit_store #(
   parameter int width = 11
) (
   input  wire logic             ref_clk,
   input  wire logic             sys_rst,
   input  wire logic             write_en,
   input  wire logic [1:0]       write_index,
   input  wire logic [width-1:0] write_data,
   input  wire logic [1:0]       read_index,
   output logic      [width-1:0] read_data,
   output logic      [width-1:0] upper,
   output logic      [width-1:0] lower,
   output logic      [width-1:0] critical
);

   // ------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------
   logic [width-1:0] mem [0:3];

   // A word narrower than two bits cannot hold a sign and a magnitude.
   if (width < 2) begin
      $error("tlar_limit_store: width too small");
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         for (int i = 0; i < 4; i++) begin
            mem[i] <= '0;
         end
      end else if (write_en) begin
         mem[write_index] <= write_data;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         read_data <= '0;
      end else begin
         read_data <= mem[read_index];
      end
   end

   assign upper    = mem[1];
   assign lower    = mem[2];
   assign critical = mem[3];

endmodule
`default_nettype wire

// [testbench/tlar_host_model.sv]
// Host controller model driving the register access port.
`timescale 1ns/10ps
`default_nettype none
module tlar_host_model (
   input  wire logic                    ref_clk,
   input  wire logic                    read_valid,
   input  wire logic [15:0]             read_data,
   output var  tlar_pkg::tlar_access_type host_access
);
   initial host_access = '0;
   // The host never raises both strobes, so a read sees settled data.
   task automatic wr(input logic [7:0] p, input logic [15:0] d);
      @(posedge ref_clk) host_access <= '{1'b1, 1'b0, p, d};
      @(posedge ref_clk) host_access <= '0;
   endtask
   task automatic rd(input logic [7:0] p, output logic [16:0] r);
      @(posedge ref_clk) host_access <= '{1'b0, 1'b1, p, 16'h0000};
      @(posedge ref_clk) host_access <= '0;
      // The answer is launched at this edge and stands for one cycle.
      @(posedge ref_clk);
      #1 r = {read_valid, read_data};
   endtask
endmodule
`default_nettype wire

// [testbench/tlar_core_properties.sv]
// Checker with concurrent properties on the limit block ports.
`timescale 1ns/10ps
`default_nettype none
module tlar_checker #(
   parameter int temp_width = 13
) (
   input wire logic                     ref_clk,
   input wire logic                     sys_rst,
   input wire tlar_pkg::tlar_access_type host_access,
   input wire logic                     read_valid,
   input wire logic [15:0]              read_data,
   input wire logic                     conversion_done,
   input wire logic [temp_width-1:0]    conversion_result,
   input wire logic                     window_lock,
   input wire logic                     alert_enable,
   input wire logic                     alert_crit_only,
   input wire logic                     alert_active
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   wire logic rd = host_access.read_en;
   wire logic [7:0] p = host_access.pointer;
   AST_READ_LAT: assert property (rd |-> ##2 read_valid)
      else $error("read answer late");
   AST_NO_SPUR: assert property (read_valid |-> $past(rd, 2))
      else $error("read answer without request");
   AST_UNMAPPED: assert property (rd && !(p inside {[2:5]})
      |-> ##2 read_data == 16'h0000) else $error("unmapped read not zero");
   AST_RSVD: assert property (rd && p inside {[2:4]} |-> ##2
      (read_data[15:13] == 3'h0 && read_data[1:0] == 2'h0))
      else $error("unused limit bits not zero");
   AST_QUARTER: assert property (rd && p == 8'h05
      |-> ##2 read_data[1:0] == 2'h0) else $error("low bits set");
   AST_LOAD: assert property (conversion_done ##1
      !conversion_done ##1 (!conversion_done && rd && p == 8'h05)
      |-> ##2 read_data[12:2] == $past(conversion_result[12:2], 4))
      else $error("ambient value not loaded");
   AST_ALERT_OFF: assert property (!alert_enable |=> !alert_active)
      else $error("alert while disabled");
   AST_STANDS: assert property (!read_valid |-> $stable(read_data))
      else $error("read data changed without answer");
   COV_READ: cover property (rd && p == 8'h05 ##2 read_valid);
   COV_CONV: cover property (conversion_done ##2 rd);
   COV_ALERT: cover property ($rose(alert_active));
endmodule
bind tlar_core tlar_checker #(.temp_width(temp_width)) chk (
   .ref_clk(ref_clk), .sys_rst(sys_rst), .host_access(host_access),
   .read_valid(read_valid), .read_data(read_data),
   .conversion_done(conversion_done),
   .conversion_result(conversion_result), .window_lock(window_lock),
   .alert_enable(alert_enable), .alert_crit_only(alert_crit_only),
   .alert_active(alert_active));
`default_nettype wire

// [testbench/temp_limit_and_ambient_regs_test.sv]
// Self-checking testbench of the limit and ambient register block.
`timescale 1ns/10ps
`default_nettype none
module temp_limit_and_ambient_regs_test;
   logic ref_clk = 0, sys_rst = 1, conversion_done = 0;
   logic window_lock = 0, alert_enable = 0, alert_crit_only = 0;
   logic [12:0] conversion_result = '0;
   logic read_valid, alert_active;
   logic [15:0] read_data;
   logic [16:0] r;
   tlar_pkg::tlar_access_type host_access;
   int n_errors = 0, comparisons = 0;
   always #50 ref_clk = ~ref_clk;
   tlar_core uut (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .host_access(host_access), .read_valid(read_valid),
      .read_data(read_data), .conversion_done(conversion_done),
      .conversion_result(conversion_result), .window_lock(window_lock),
      .alert_enable(alert_enable), .alert_crit_only(alert_crit_only),
      .alert_active(alert_active));
   tlar_host_model host (.ref_clk(ref_clk), .read_valid(read_valid),
      .read_data(read_data), .host_access(host_access));
   task automatic chk(string n, logic [16:0] e, logic [16:0] g);
      comparisons++;
      if (g !== e) begin
         n_errors++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic conv(logic [12:0] t);
      @(posedge ref_clk) {conversion_done, conversion_result} <= {1'b1, t};
      @(posedge ref_clk) conversion_done <= 0;
   endtask
   task automatic rdchk(string n, logic [7:0] p, logic [15:0] e);
      host.rd(p, r);
      chk(n, {1'b1, e}, r);
   endtask
   task automatic t_reset;
      logic [7:0] ps[5] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h07};
      foreach (ps[i]) rdchk("reset", ps[i], 16'h0000);
      $display("test reset done");
   endtask
   task automatic t_fields;
      for (int i = 2; i < 5; i++) begin
         host.wr(i[7:0], 16'hFFFF);
         rdchk("limit", i[7:0], 16'h1FFC);
      end
      host.wr(8'h05, 16'h1234);
      rdchk("ambient ro", 8'h05, 16'h0000);
      $display("test fields done");
   endtask
   task automatic t_lock;
      @(posedge ref_clk) window_lock <= 1;
      host.wr(8'h02, 16'h0140);
      host.wr(8'h03, 16'h00A0);
      host.wr(8'h04, 16'h01E0);
      rdchk("locked upper", 8'h02, 16'h1FFC);
      rdchk("locked lower", 8'h03, 16'h1FFC);
      rdchk("crit", 8'h04, 16'h01E0);
      @(posedge ref_clk) window_lock <= 0;
      host.wr(8'h02, 16'h0140);
      host.wr(8'h03, 16'h00A0);
      rdchk("unlocked", 8'h02, 16'h0140);
      $display("test lock done");
   endtask
   // Limits here are 20, 10 and 30 degrees; edges sit on each bound.
   task automatic t_flags;
      logic [12:0] tt[6] = '{13'h0050, 13'h00A0, 13'h0140, 13'h0144,
                             13'h01E3, 13'h1FF0};
      logic [15:0] ee[6] = '{16'h2050, 16'h00A0, 16'h0140, 16'h4144,
                             16'hC1E0, 16'h3FF0};
      @(posedge ref_clk) alert_enable <= 1;
      foreach (tt[i]) begin
         conv(tt[i]);
         rdchk("ambient", 8'h05, ee[i]);
         chk("alert", 17'(ee[i][15:13] != 0), 17'(alert_active));
      end
      $display("test flags done");
   endtask
   task automatic t_mode;
      @(posedge ref_clk) alert_crit_only <= 1;
      conv(13'h0190);
      rdchk("above upper", 8'h05, 16'h4190);
      chk("crit only", 17'h0, 17'(alert_active));
      conv(13'h01E0);
      #1 chk("crit alert", 17'h1, 17'(alert_active));
      @(posedge ref_clk) alert_enable <= 0;
      @(posedge ref_clk);
      #1 chk("disabled", 17'h0, 17'(alert_active));
      host.wr(8'h02, 16'h01F0);
      conv(13'h0190);
      rdchk("new limit", 8'h05, 16'h0190);
      $display("test mode done");
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge ref_clk);
      sys_rst <= 0;
      t_reset;
      t_fields;
      t_lock;
      t_flags;
      t_mode;
      end_of_test;
   end
   // Whole run is about 110 cycles; the 10000-cycle limit allows a wide margin.
   initial begin
      #1000000;
      n_errors++;
      end_of_test;
   end
endmodule
`default_nettype wire
